// *** hdl/rss_alu.sv ***
// combinational rotate and subtract unit
`timescale 1ns/1ps
`default_nettype none
`include "rss_params.svh"
module rss_alu (
    rss_alu_if.unit bus
);
    logic                    addIn;
    logic [`RSS_DATA_W:0]    sum;
    logic [`RSS_NIB_W:0]     nibSum;

    // subtraction is opnd + ~acc + 1, or + carry-in for the borrow form; carry then reads as not-borrow
    always_comb begin
        addIn  = (bus.op == rss_pkg::RSS_OP_SUB_ACC_FROM_FILE_BRW) ?
                 bus.carryIn : 1'b1;
        sum    = {1'b0, bus.opnd} + {1'b0, ~bus.acc}
                 + {{`RSS_DATA_W{1'b0}}, addIn};
        nibSum = {1'b0, bus.opnd[`RSS_NIB_W-1:0]}
                 + {1'b0, ~bus.acc[`RSS_NIB_W-1:0]}
                 + {{`RSS_NIB_W{1'b0}}, addIn};
        if (bus.op == rss_pkg::RSS_OP_ROTATE_RIGHT_VIA_CARRY) begin
            bus.result   = {bus.carryIn,
                            bus.opnd[`RSS_DATA_W-1:1]};
            bus.carryOut = bus.opnd[0];
        end else begin
            bus.result   = sum[`RSS_DATA_W-1:0];
            bus.carryOut = sum[`RSS_DATA_W];
        end
        bus.digitOut = nibSum[`RSS_NIB_W];
        bus.zeroOut  = (bus.result == `RSS_BYTE_ZERO);
    end
endmodule
`default_nettype wire

// *** hdl/rss_alu_if.sv ***
// operand and result bundle between the execution block and its unit
`timescale 1ns/1ps
`default_nettype none
interface rss_alu_if;
    rss_pkg::rss_op_t op;
    logic [7:0]       opnd;
    logic [7:0]       acc;
    logic             carryIn;
    logic [7:0]       result;
    logic             carryOut;
    logic             digitOut;
    logic             zeroOut;

    modport exec (output op, opnd, acc, carryIn,
                  input  result, carryOut, digitOut, zeroOut);
    modport unit (input  op, opnd, acc, carryIn,
                  output result, carryOut, digitOut, zeroOut);
endinterface
`default_nettype wire

// *** hdl/rss_exec.sv ***
// execution datapath for rotate, subtract and power-down instructions
`timescale 1ns/1ps
`default_nettype none
`include "rss_params.svh"

// How it works
// - rotate right through carry, only carry changes
// - destination bit 0 to accumulator, 1 file
// - literal minus accumulator, two's complement arithmetic
// - literal subtract: result to accumulator, C DC Z
// - file minus accumulator, C DC Z by compare
// - file minus accumulator minus inverted carry
// - power-down clears PD, sets TO only
// - power-down pulses watchdogClear for one enabled cycle
// - power-down halts oscillator until wake-up
module rss_exec (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             clkEn,
    input  wire logic             instrValid,
    input  wire rss_pkg::rss_op_t opcode,
    input  wire logic [6:0]       fileAddr,
    input  wire logic             destSel,
    input  wire logic [7:0]       literal,
    input  wire logic [7:0]       fileRdData,
    input  wire logic             wakeUp,
    input  wire logic [1:0]       regAddr,
    input  wire logic [7:0]       regWrData,
    input  wire logic             regWr,
    input  wire logic             regRd,
    output logic [7:0]            regRdData,
    output logic [7:0]            accOut,
    output logic                  carryFlag,
    output logic                  digitCarryFlag,
    output logic                  zeroFlag,
    output logic                  timeoutStatusBit,
    output logic                  powerdownStatusBit,
    output logic                  sleeping,
    output logic                  oscRun,
    output logic                  watchdogClear,
    output logic                  fileWrEn,
    output logic [6:0]            fileWrAddr,
    output logic [7:0]            fileWrData
);
    // ---------------------------------------------------------------
    // state and arithmetic unit
    // ---------------------------------------------------------------
    rss_pkg::rss_state_t st_r;
    rss_pkg::rss_state_t st_nxt;
    logic                exec;
    logic                fileOp;
    logic                subOp;

    rss_alu_if aluBus ();

    rss_alu u_alu (
        .bus (aluBus.unit)
    );

    // the decoder guarantees operands arrive with the opcode
    assign exec   = instrValid && !st_r.sleeping;
    assign fileOp = (opcode == rss_pkg::RSS_OP_ROTATE_RIGHT_VIA_CARRY) ||
                    (opcode == rss_pkg::RSS_OP_SUB_ACC_FROM_FILE) ||
                    (opcode == rss_pkg::RSS_OP_SUB_ACC_FROM_FILE_BRW);
    assign subOp  = fileOp &&
                    (opcode != rss_pkg::RSS_OP_ROTATE_RIGHT_VIA_CARRY) ||
                    (opcode == rss_pkg::RSS_OP_SUB_ACC_FROM_LITERAL);

    assign aluBus.op      = opcode;
    assign aluBus.opnd    = (opcode == rss_pkg::RSS_OP_SUB_ACC_FROM_LITERAL)
                            ? literal : fileRdData;
    assign aluBus.acc     = st_r.acc;
    assign aluBus.carryIn = st_r.carry;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    // an instruction in the same cycle as a bus write wins, so flags
    // set by execution are never lost to a software write
    always_comb begin
        st_nxt               = st_r;
        st_nxt.watchdogClear = 1'b0;
        st_nxt.fileWrEn      = 1'b0;
        if (regWr) begin
            unique case (regAddr)
                `RSS_REG_ACC: begin
                    st_nxt.acc = regWrData;
                end
                `RSS_REG_STATUS: begin
                    st_nxt.carry      = regWrData[`RSS_STAT_C];
                    st_nxt.digitCarry = regWrData[`RSS_STAT_DC];
                    st_nxt.zero       = regWrData[`RSS_STAT_Z];
                end
                default: begin
                end
            endcase
        end
        if (regRd) begin
            unique case (regAddr)
                `RSS_REG_ACC: begin
                    st_nxt.rdData = st_r.acc;
                end
                `RSS_REG_STATUS: begin
                    st_nxt.rdData = `RSS_BYTE_ZERO;
                    st_nxt.rdData[`RSS_STAT_C]  = st_r.carry;
                    st_nxt.rdData[`RSS_STAT_DC] = st_r.digitCarry;
                    st_nxt.rdData[`RSS_STAT_Z]  = st_r.zero;
                    st_nxt.rdData[`RSS_STAT_PD] = st_r.powerdownStatus;
                    st_nxt.rdData[`RSS_STAT_TO] = st_r.timeoutStatus;
                end
                default: begin
                    st_nxt.rdData = `RSS_BYTE_ZERO;
                end
            endcase
        end
        if (st_r.sleeping && wakeUp) begin
            st_nxt.sleeping = 1'b0;
            st_nxt.oscRun   = 1'b1;
        end
        if (exec) begin
            unique case (opcode)
                rss_pkg::RSS_OP_ROTATE_RIGHT_VIA_CARRY: begin
                    st_nxt.carry      = aluBus.carryOut;
                    st_nxt.fileWrData = aluBus.result;
                end
                rss_pkg::RSS_OP_SUB_ACC_FROM_LITERAL,
                rss_pkg::RSS_OP_SUB_ACC_FROM_FILE,
                rss_pkg::RSS_OP_SUB_ACC_FROM_FILE_BRW: begin
                    st_nxt.carry      = aluBus.carryOut;
                    st_nxt.digitCarry = aluBus.digitOut;
                    st_nxt.zero       = aluBus.zeroOut;
                    st_nxt.fileWrData = aluBus.result;
                end
                rss_pkg::RSS_OP_SLEEP: begin
                    st_nxt.powerdownStatus = 1'b0;
                    st_nxt.timeoutStatus   = 1'b1;
                    st_nxt.watchdogClear   = 1'b1;
                    st_nxt.sleeping        = 1'b1;
                    st_nxt.oscRun          = 1'b0;
                end
                default: begin
                end
            endcase
            if (opcode == rss_pkg::RSS_OP_SUB_ACC_FROM_LITERAL) begin
                st_nxt.acc = aluBus.result;
            end else if (fileOp) begin
                if (destSel) begin
                    st_nxt.fileWrEn   = 1'b1;
                    st_nxt.fileWrAddr = fileAddr;
                end else begin
                    st_nxt.acc = aluBus.result;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            st_r.acc             <= `RSS_ACC_RST;
            st_r.carry           <= 1'b0;
            st_r.digitCarry      <= 1'b0;
            st_r.zero            <= 1'b0;
            st_r.timeoutStatus   <= `RSS_TO_RST;
            st_r.powerdownStatus <= `RSS_PD_RST;
            st_r.sleeping        <= 1'b0;
            st_r.oscRun          <= 1'b1;
            st_r.watchdogClear   <= 1'b0;
            st_r.fileWrEn        <= 1'b0;
            st_r.fileWrAddr      <= `RSS_ADDR_ZERO;
            st_r.fileWrData      <= `RSS_BYTE_ZERO;
            st_r.rdData          <= `RSS_BYTE_ZERO;
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    assign regRdData          = st_r.rdData;
    assign accOut             = st_r.acc;
    assign carryFlag          = st_r.carry;
    assign digitCarryFlag     = st_r.digitCarry;
    assign zeroFlag           = st_r.zero;
    assign timeoutStatusBit   = st_r.timeoutStatus;
    assign powerdownStatusBit = st_r.powerdownStatus;
    assign sleeping           = st_r.sleeping;
    assign oscRun             = st_r.oscRun;
    assign watchdogClear      = st_r.watchdogClear;
    assign fileWrEn           = st_r.fileWrEn;
    assign fileWrAddr         = st_r.fileWrAddr;
    assign fileWrData         = st_r.fileWrData;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence sq_go(rss_pkg::rss_op_t o);
        clkEn && exec && !regWr && opcode == o;
    endsequence

    sequence sq_asleep;
        st_r.sleeping && !st_r.oscRun && st_r.watchdogClear;
    endsequence

    a_rotate_value: assert property (
        sq_go(rss_pkg::RSS_OP_ROTATE_RIGHT_VIA_CARRY) |=>
        st_r.fileWrData == {$past(st_r.carry), $past(fileRdData[7:1])} &&
        st_r.carry == $past(fileRdData[0]) &&
        $stable(st_r.zero) && $stable(st_r.digitCarry))
        else $error("rotate result or flags wrong");

    a_dest_file: assert property (
        clkEn && exec && fileOp && destSel |=>
        st_r.fileWrEn && st_r.fileWrAddr == $past(fileAddr))
        else $error("file destination not written");

    a_dest_acc: assert property (
        clkEn && exec && fileOp && !destSel && !regWr |=>
        !st_r.fileWrEn && st_r.acc == st_r.fileWrData)
        else $error("accumulator destination not written");

    a_literal_sub: assert property (
        sq_go(rss_pkg::RSS_OP_SUB_ACC_FROM_LITERAL) |=>
        st_r.acc == 8'($past(literal) - $past(st_r.acc)))
        else $error("literal subtract value wrong");

    a_literal_flags: assert property (
        sq_go(rss_pkg::RSS_OP_SUB_ACC_FROM_LITERAL) |=>
        st_r.carry == ($past(st_r.acc) <= $past(literal)) &&
        st_r.digitCarry == ($past(st_r.acc[3:0]) <= $past(literal[3:0])))
        else $error("literal subtract flags wrong");

    a_file_flags: assert property (
        sq_go(rss_pkg::RSS_OP_SUB_ACC_FROM_FILE) |=>
        st_r.fileWrData == 8'($past(fileRdData) - $past(st_r.acc)) &&
        st_r.carry == ($past(st_r.acc) <= $past(fileRdData)))
        else $error("file subtract wrong");

    a_borrow_sub: assert property (
        sq_go(rss_pkg::RSS_OP_SUB_ACC_FROM_FILE_BRW) |=>
        st_r.fileWrData == 8'($past(fileRdData) - $past(st_r.acc)
                              - {7'h00, !$past(st_r.carry)}))
        else $error("borrow subtract value wrong");

    a_sleep_status: assert property (
        sq_go(rss_pkg::RSS_OP_SLEEP) |=>
        st_r.timeoutStatus && !st_r.powerdownStatus &&
        $stable(st_r.carry) && $stable(st_r.zero))
        else $error("power-down status bits wrong");

    a_sleep_enter: assert property (
        sq_go(rss_pkg::RSS_OP_SLEEP) |=>
        sq_asleep ##1 (!st_r.watchdogClear || !$past(clkEn)))
        else $error("watchdog clear or sleep entry wrong");

    a_sleep_hold: assert property (
        clkEn && st_r.sleeping && !wakeUp |=>
        st_r.sleeping && !st_r.fileWrEn && !st_r.oscRun)
        else $error("instruction ran while asleep");

    a_zero_flag: assert property (
        clkEn && exec && subOp && !regWr |=>
        st_r.zero == (st_r.fileWrData == 8'h00))
        else $error("zero flag mismatch");
endmodule
`default_nettype wire

// *** hdl/rss_params.svh ***
// constants for the rotate, subtract and power-down execution block
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH

`define RSS_DATA_W       8
`define RSS_FADDR_W      7
`define RSS_NIB_W        4
`define RSS_RADDR_W      2

`define RSS_REG_ACC      2'h0
`define RSS_REG_STATUS   2'h1

`define RSS_STAT_C       0
`define RSS_STAT_DC      1
`define RSS_STAT_Z       2
`define RSS_STAT_PD      3
`define RSS_STAT_TO      4

`define RSS_ACC_RST      8'h00
`define RSS_BYTE_ZERO    8'h00
`define RSS_ADDR_ZERO    7'h00
`define RSS_TO_RST       1'b1
`define RSS_PD_RST       1'b1

`endif

// *** hdl/rss_pkg.sv ***
// types shared by the execution block and its arithmetic unit
package rss_pkg;

    typedef enum logic [2:0] {
        RSS_OP_NONE                   = 3'h0,
        RSS_OP_ROTATE_RIGHT_VIA_CARRY = 3'h1,
        RSS_OP_SUB_ACC_FROM_LITERAL   = 3'h2,
        RSS_OP_SUB_ACC_FROM_FILE      = 3'h3,
        RSS_OP_SUB_ACC_FROM_FILE_BRW  = 3'h4,
        RSS_OP_SLEEP                  = 3'h5
    } rss_op_t;

    typedef struct packed {
        logic [7:0] acc;
        logic       carry;
        logic       digitCarry;
        logic       zero;
        logic       timeoutStatus;
        logic       powerdownStatus;
        logic       sleeping;
        logic       oscRun;
        logic       watchdogClear;
        logic       fileWrEn;
        logic [6:0] fileWrAddr;
        logic [7:0] fileWrData;
        logic [7:0] rdData;
    } rss_state_t;

endpackage

// *** sim/rss_file_model.sv ***
// behavioural file register memory and operand source beside the block
`timescale 1ns/1ps
`default_nettype none
module rss_file_model (
    input  wire logic       clk,
    input  wire logic [6:0] fileAddr,
    output logic [7:0]      fileRdData,
    input  wire logic       fileWrEn,
    input  wire logic [6:0] fileWrAddr,
    input  wire logic [7:0] fileWrData
);
    logic [7:0] mem [0:127];

    // no forwarding: a write lands at the edge after the pulse
    assign fileRdData = mem[fileAddr];

    always @(posedge clk) begin
        if (fileWrEn === 1'h1) begin
            mem[fileWrAddr] <= fileWrData;
        end
    end

    task automatic poke(input logic [6:0] a, input logic [7:0] v);
        mem[a] = v;
    endtask

    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'hA5 ^ 8'(i);
        end
    end
endmodule
`default_nettype wire

// *** sim/tb_rotate_subtract_sleep_exec.sv ***
// self-checking bench for the rotate, subtract and power-down block
`timescale 1ns/1ps
`default_nettype none
module tb_rotate_subtract_sleep_exec;
    logic             clk, reset, clkEn, instrValid, destSel, wakeUp;
    rss_pkg::rss_op_t opcode;
    logic [6:0]       fileAddr, fileWrAddr;
    logic [7:0]       literal, fileRdData, regWrData, regRdData;
    logic [7:0]       accOut, fileWrData;
    logic [1:0]       regAddr;
    logic             regWr, regRd, carryFlag, digitCarryFlag, zeroFlag;
    logic             timeoutStatusBit, powerdownStatusBit, sleeping;
    logic             oscRun, watchdogClear, fileWrEn;
    int               errors;
    int               comparisons;

    localparam rss_pkg::rss_op_t opRot =
        rss_pkg::RSS_OP_ROTATE_RIGHT_VIA_CARRY;
    localparam rss_pkg::rss_op_t opLit =
        rss_pkg::RSS_OP_SUB_ACC_FROM_LITERAL;
    localparam rss_pkg::rss_op_t opFile =
        rss_pkg::RSS_OP_SUB_ACC_FROM_FILE;
    localparam rss_pkg::rss_op_t opBrw =
        rss_pkg::RSS_OP_SUB_ACC_FROM_FILE_BRW;

    rss_exec uut (.clk(clk), .reset(reset), .clkEn(clkEn),
        .instrValid(instrValid), .opcode(opcode), .fileAddr(fileAddr),
        .destSel(destSel), .literal(literal), .fileRdData(fileRdData),
        .wakeUp(wakeUp), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .accOut(accOut), .carryFlag(carryFlag),
        .digitCarryFlag(digitCarryFlag), .zeroFlag(zeroFlag),
        .timeoutStatusBit(timeoutStatusBit),
        .powerdownStatusBit(powerdownStatusBit), .sleeping(sleeping),
        .oscRun(oscRun), .watchdogClear(watchdogClear),
        .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr),
        .fileWrData(fileWrData));

    rss_file_model mem (.clk(clk), .fileAddr(fileAddr),
        .fileRdData(fileRdData), .fileWrEn(fileWrEn),
        .fileWrAddr(fileWrAddr), .fileWrData(fileWrData));

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic regWrite(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'h1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'h0;
    endtask

    task automatic regRead(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        regRd <= 1'h1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'h0;
        #1;
        chk8(regRdData, exp);
    endtask

    // results are settled 1 ns after the edge that takes the opcode
    task automatic exec(input rss_pkg::rss_op_t op, input logic [6:0] a,
                        input logic d, input logic [7:0] lit);
        @(posedge clk);
        instrValid <= 1'h1;
        opcode <= op;
        fileAddr <= a;
        destSel <= d;
        literal <= lit;
        @(posedge clk);
        instrValid <= 1'h0;
        opcode <= rss_pkg::RSS_OP_NONE;
        #1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // f doubles as the literal; st holds preset {Z, DC, C}
    task automatic runCase(input rss_pkg::rss_op_t op, input logic [7:0] f,
                           input logic [7:0] w, input logic [2:0] st,
                           input logic [6:0] a, input logic d);
        logic [8:0] full;
        logic [4:0] nib;
        logic       bin;
        logic [7:0] res;
        logic [2:0] fl;
        mem.poke(a, f);
        regWrite(2'h0, w);
        regWrite(2'h1, {5'h00, st});
        if (op == rss_pkg::RSS_OP_ROTATE_RIGHT_VIA_CARRY) begin
            res = {st[0], f[7:1]};
            fl = {st[2:1], f[0]};
        end else begin
            bin = (op == rss_pkg::RSS_OP_SUB_ACC_FROM_FILE_BRW) & ~st[0];
            full = {1'h0, f} - {1'h0, w} - {8'h00, bin};
            nib = {1'h0, f[3:0]} - {1'h0, w[3:0]} - {4'h0, bin};
            res = full[7:0];
            fl = {res == 8'h00, ~nib[4], ~full[8]};
        end
        exec(op, a, d, f);
        chk8({5'h00, zeroFlag, digitCarryFlag, carryFlag},
             {5'h00, fl});
        if (op == rss_pkg::RSS_OP_SUB_ACC_FROM_LITERAL || d == 1'h0) begin
            chk8(accOut, res);
            chk8({7'h00, fileWrEn}, 8'h00);
        end else begin
            chk8({fileWrEn, fileWrAddr}, {1'h1, a});
            chk8(fileWrData, res);
            chk8(accOut, w);
        end
    endtask

    task automatic regCase;
        regRead(2'h1, 8'h18);
        regRead(2'h2, 8'h00);
        regWrite(2'h3, 8'hFF);
        regWrite(2'h1, 8'hFF);
        regRead(2'h1, 8'h1F);
        regWrite(2'h0, 8'h5A);
        regRead(2'h0, 8'h5A);
    endtask

    task automatic sleepCase;
        logic [7:0] accKeep;
        regWrite(2'h1, 8'h05);
        accKeep = accOut;
        exec(rss_pkg::RSS_OP_SLEEP, 7'h00, 1'h0, 8'h00);
        chk8({sleeping, oscRun, watchdogClear, timeoutStatusBit,
              powerdownStatusBit, zeroFlag, digitCarryFlag, carryFlag},
             8'hB5);
        @(posedge clk);
        #1;
        chk8({7'h00, watchdogClear}, 8'h00);
        exec(opLit, 7'h00, 1'h0, 8'h44);
        chk8(accOut, accKeep);
        regRead(2'h1, 8'h15);
        @(posedge clk);
        wakeUp <= 1'h1;
        @(posedge clk);
        wakeUp <= 1'h0;
        #1;
        chk8({6'h00, sleeping, oscRun}, 8'h01);
    endtask

    // a stalled enable must hold the accumulator
    task automatic freezeCase;
        logic [7:0] accKeep;
        accKeep = accOut;
        @(posedge clk);
        clkEn <= 1'h0;
        exec(opLit, 7'h00, 1'h0, 8'hFF);
        chk8(accOut, accKeep);
        @(posedge clk);
        clkEn <= 1'h1;
    endtask

    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        #(25 * 4000);
        errors++;
        tally_and_finish;
    end

    initial begin
        {reset, clkEn, instrValid, destSel, wakeUp, regWr, regRd} = 7'h60;
        opcode = rss_pkg::RSS_OP_NONE;
        {fileAddr, literal, regAddr, regWrData} = 25'h0000000;
        errors = 0;
        comparisons = 0;
        repeat (8) @(posedge clk);
        reset <= 1'h0;
        regCase;
        runCase(opRot, 8'h81, 8'h33, 3'h7, 7'h7F, 1'h1);
        runCase(opRot, 8'hC0, 8'h33, 3'h0, 7'h00, 1'h0);
        runCase(opLit, 8'h05, 8'h03, 3'h6, 7'h01, 1'h0);
        runCase(opLit, 8'h03, 8'h05, 3'h1, 7'h01, 1'h1);
        runCase(opLit, 8'h10, 8'h01, 3'h5, 7'h01, 1'h0);
        runCase(opLit, 8'h00, 8'h00, 3'h0, 7'h01, 1'h0);
        runCase(opLit, 8'hFF, 8'h00, 3'h4, 7'h01, 1'h0);
        runCase(opFile, 8'h10, 8'h01, 3'h4, 7'h12, 1'h1);
        runCase(opFile, 8'h05, 8'h05, 3'h0, 7'h7F, 1'h0);
        runCase(opFile, 8'h03, 8'h04, 3'h7, 7'h00, 1'h1);
        runCase(opBrw, 8'h10, 8'h01, 3'h6, 7'h20, 1'h0);
        runCase(opBrw, 8'h05, 8'h04, 3'h6, 7'h21, 1'h1);
        runCase(opBrw, 8'h00, 8'h00, 3'h7, 7'h22, 1'h1);
        runCase(opBrw, 8'h00, 8'h00, 3'h6, 7'h23, 1'h0);
        freezeCase;
        sleepCase;
        tally_and_finish;
    end
endmodule
`default_nettype wire
